/* File: design/aio_defines.vh */
`ifndef AIO_DEFINES_VH
`define AIO_DEFINES_VH
// ==========================================
// widths and fixed-point figures (hundredths of a percent)
`define AIO_PW          18
`define AIO_PCT_FULL    18'sh2710
`define AIO_PCT_MAX     18'sh7530
`define AIO_PCT_MIN     (-18'sh7530)
`define AIO_PCT_44      18'sh1130
// ==========================================
// low end and span of each input range, raw percent
`define AIO_LO_2V       18'sh7d0
`define AIO_LO_1V       18'sh3e8
`define AIO_LO_4MA      18'sh370
`define AIO_SPAN_8V     18'sh1f40
`define AIO_SPAN_5V     18'sh1388
`define AIO_SPAN_4V     18'sh0fa0
`define AIO_SPAN_16MA   18'sh0dc0
// ==========================================
// converter codes: full span, live-zero span and live-zero start
`define AIO_CODE_SPAN   34'h0ffff
`define AIO_CODE_LIVE   34'h0cccc
`define AIO_CODE_BASE   34'h03333
// ==========================================
// input range kinds
`define AIO_IN_0_10V    4'h0
`define AIO_IN_2_10V    4'h1
`define AIO_IN_0_5V     4'h2
`define AIO_IN_1_5V     4'h3
`define AIO_IN_PM10V    4'h4
`define AIO_IN_0_20MA   4'h5
`define AIO_IN_4_20MA   4'h6
`define AIO_IN_20_4MA   4'h7
`define AIO_IN_20_0MA   4'h8
// ==========================================
// output range kinds
`define AIO_OUT_0_10V   2'h0
`define AIO_OUT_0_20MA  2'h1
`define AIO_OUT_4_20MA  2'h2
// ==========================================
// break thresholds as raw hardware percentage
// 0.1V of 10V = 1.00% ; 0.45mA of 20mA on 44% scale = 0.99%
`define AIO_BRK_VOLT    18'sh64
`define AIO_BRK_AMP     18'sh63
`endif

/* File: design/aio_in_chan.v */
`include "aio_defines.vh"
module aio_in_chan (
  input  wire                     clock,
  input  wire                     srst,
  input  wire signed [17:0]       raw,
  input  wire [3:0]               range_kind,
  input  wire signed [17:0]       scale,
  input  wire signed [17:0]       offset,
  input  wire                     break_enable,
  input  wire signed [17:0]       break_value,
  input  wire signed [17:0]       level,
  input  wire signed [17:0]       noise_margin,
  input  wire                     invert,
  output reg  signed [17:0]       value_r,
  output reg                      lost_r,
  output wire                     break_enable_eff,
  output reg                      thr_value_r
);
  // ==========================================
  // normalise raw reading to 0..10000 of the selected range
  reg signed [17:0] lo;
  reg signed [17:0] span;
  reg               is_amp;
  reg               brk_ok;
  always @* begin
    lo = 18'sh0;
    span = `AIO_PCT_FULL;
    is_amp = 1'b0;
    brk_ok = 1'b0;
    case (range_kind)
      `AIO_IN_0_10V: lo = 18'sh0;
      `AIO_IN_2_10V: begin
        lo = `AIO_LO_2V;
        span = `AIO_SPAN_8V;
        brk_ok = 1'b1;
      end
      `AIO_IN_0_5V: span = `AIO_SPAN_5V;
      `AIO_IN_1_5V: begin
        lo = `AIO_LO_1V;
        span = `AIO_SPAN_4V;
        brk_ok = 1'b1;
      end
      `AIO_IN_PM10V: lo = 18'sh0;
      `AIO_IN_0_20MA: begin
        span = `AIO_PCT_44;
        is_amp = 1'b1;
      end
      `AIO_IN_4_20MA, `AIO_IN_20_4MA: begin
        lo = `AIO_LO_4MA;
        span = `AIO_SPAN_16MA;
        is_amp = 1'b1;
        brk_ok = 1'b1;
      end
      `AIO_IN_20_0MA: begin
        span = `AIO_PCT_44;
        is_amp = 1'b1;
      end
      default: lo = 18'sh0;
    endcase
  end
  wire signed [35:0] num  = (raw - lo) * 36'sh2710;
  wire signed [35:0] q    = num / span;
  wire signed [35:0] norm = ((range_kind == `AIO_IN_20_4MA) || (range_kind == `AIO_IN_20_0MA)) ?
                            (36'sh2710 - q) : q;
  // ==========================================
  // scale then offset
  wire signed [53:0] prod = norm * scale;
  wire signed [53:0] scl  = prod / 54'sh2710 + offset;
  wire signed [17:0] clip = (scl > 54'sh7530) ? `AIO_PCT_MAX :
                            (scl < -54'sh7530) ? `AIO_PCT_MIN : scl[17:0];
  // ==========================================
  // break detect
  assign break_enable_eff = break_enable & brk_ok;
  wire lost = break_enable_eff & (raw < (is_amp ? `AIO_BRK_AMP : `AIO_BRK_VOLT));
  // ==========================================
  // hysteresis comparator
  reg               last_r;
  wire signed [18:0] thr = last_r ? (level - noise_margin) : (level + noise_margin);
  wire cmp = ($signed({raw[17], raw}) > thr) ? 1'b1 : (($signed({raw[17], raw}) < thr) ? 1'b0 : last_r);
  always @(posedge clock) begin
    if (srst) begin
      value_r <= 18'sh0;
      lost_r <= 1'b0;
      last_r <= 1'b0;
      thr_value_r <= 1'b0;
    end else begin
      value_r <= lost ? break_value : clip;
      lost_r <= lost;
      last_r <= cmp;
      thr_value_r <= cmp ^ invert;
    end
  end
endmodule

/* File: design/aio_top.v */
// Notes on behaviour
// - comparator threshold is level minus margin after true, plus margin after false.
// - uninverted result true above threshold, false below.
// - invert flag flips the comparator output.
// - raw reading is percent; 20mA reads 44%, voltage top reads 100%.
// - normalised reading is multiplied by scale; 100% scale gives 0..100%.
// - signed offset added after scaling; both span plus or minus 300%.
// - input range codes 0..8 select voltage and current ranges.
// - break detect only on 2-10V, 1-5V, 4-20mA, 20-4mA; else enable reads false.
// - break declared below 0.1V or 0.45mA when detection enabled.
// - during break the result is the substitute value.
// - disabled detection gives no substitution and no flag.
// - two independent input channels, each with scaling and comparator.
// - output demand multiplied by scale; 100% leaves it unchanged.
// - output offset added after scaling; 0% leaves it unchanged.
// - magnitude mode takes absolute value, otherwise negatives clamp at zero.
// - result 0 drives range low end, 100% drives high end.
// - output range codes 0 is 0-10V, 1 is 0-20mA, 2 is 4-20mA.
`include "aio_defines.vh"
module aio_top (
  input  wire               clock,
  input  wire               srst,
  input  wire signed [17:0] ch1_raw,
  input  wire [3:0]         ch1_range_kind,
  input  wire signed [17:0] ch1_scale,
  input  wire signed [17:0] ch1_offset,
  input  wire               ch1_break_enable,
  input  wire signed [17:0] ch1_break_value,
  input  wire signed [17:0] ch1_level,
  input  wire signed [17:0] ch1_noise_margin,
  input  wire               ch1_invert,
  output wire signed [17:0] ch1_value,
  output wire               ch1_lost,
  output wire               ch1_break_enable_eff,
  output wire               ch1_analog_threshold_input,
  input  wire signed [17:0] ch2_raw,
  input  wire [3:0]         ch2_range_kind,
  input  wire signed [17:0] ch2_scale,
  input  wire signed [17:0] ch2_offset,
  input  wire               ch2_break_enable,
  input  wire signed [17:0] ch2_break_value,
  input  wire signed [17:0] ch2_level,
  input  wire signed [17:0] ch2_noise_margin,
  input  wire               ch2_invert,
  output wire signed [17:0] ch2_value,
  output wire               ch2_lost,
  output wire               ch2_break_enable_eff,
  output wire               ch2_analog_threshold_input,
  input  wire signed [17:0] out_demand,
  input  wire signed [17:0] out_scale,
  input  wire signed [17:0] out_offset,
  input  wire               magnitude_select,
  input  wire [1:0]         out_range_kind,
  output reg  signed [17:0] out_percent_r,
  output reg  [15:0]        out_code_r
);
  // ==========================================
  // input channels
  aio_in_chan u_ch1 (
    .clock            (clock),
    .srst             (srst),
    .raw              (ch1_raw),
    .range_kind       (ch1_range_kind),
    .scale            (ch1_scale),
    .offset           (ch1_offset),
    .break_enable     (ch1_break_enable),
    .break_value      (ch1_break_value),
    .level            (ch1_level),
    .noise_margin     (ch1_noise_margin),
    .invert           (ch1_invert),
    .value_r          (ch1_value),
    .lost_r           (ch1_lost),
    .break_enable_eff (ch1_break_enable_eff),
    .thr_value_r      (ch1_analog_threshold_input)
  );
  aio_in_chan u_ch2 (
    .clock            (clock),
    .srst             (srst),
    .raw              (ch2_raw),
    .range_kind       (ch2_range_kind),
    .scale            (ch2_scale),
    .offset           (ch2_offset),
    .break_enable     (ch2_break_enable),
    .break_value      (ch2_break_value),
    .level            (ch2_level),
    .noise_margin     (ch2_noise_margin),
    .invert           (ch2_invert),
    .value_r          (ch2_value),
    .lost_r           (ch2_lost),
    .break_enable_eff (ch2_break_enable_eff),
    .thr_value_r      (ch2_analog_threshold_input)
  );
  // ==========================================
  // output path: scale, offset, magnitude or clamp
  wire signed [35:0] oprod = out_demand * out_scale;
  wire signed [35:0] osum  = oprod / 36'sh2710 + out_offset;
  wire signed [35:0] omag  = (osum < 36'sh0) ? (magnitude_select ? -osum : 36'sh0) : osum;
  wire signed [17:0] oclip = (omag > 36'sh7530) ? `AIO_PCT_MAX : omag[17:0];
  // ==========================================
  // converter code: 0..65535 over the selected range, 4-20mA starts at 20%
  wire [17:0]  osat  = (oclip > `AIO_PCT_FULL) ? `AIO_PCT_FULL : oclip;
  wire [33:0]  full  = osat * `AIO_CODE_SPAN / 34'h2710;
  wire [33:0]  live  = osat * `AIO_CODE_LIVE / 34'h2710 + `AIO_CODE_BASE;
  always @(posedge clock) begin
    if (srst) begin
      out_percent_r <= 18'sh0;
      out_code_r <= 16'h0000;
    end else begin
      out_percent_r <= oclip;
      case (out_range_kind)
        `AIO_OUT_4_20MA: out_code_r <= live[15:0];
        default:         out_code_r <= full[15:0];
      endcase
    end
  end
endmodule

/* File: bench/aio_conv_model.sv */
// ==========================================
// converter front end: level in mV or uA to raw percent
module aio_conv_model (
  input  var int                 level,
  input  wire logic [3:0]        kind,
  output logic signed [17:0]     raw
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    if (kind > 4'h4) raw = 18'(level * 4400 / 20000);
    else if (kind == 4'h4) raw = 18'((level + 10000) / 2);
    else raw = 18'(level);
  end
endmodule

/* File: bench/aio_top_properties.sv */
// ==========================================
// port assertions for aio_top
module aio_top_chk (
  input wire logic               clock,
  input wire logic               srst,
  input wire logic               ch1_break_enable,
  input wire logic               ch1_invert,
  input wire logic               ch1_lost,
  input wire logic               ch1_break_enable_eff,
  input wire logic               ch1_analog_threshold_input,
  input wire logic [3:0]         ch1_range_kind,
  input wire logic [1:0]         out_range_kind,
  input wire logic [15:0]        out_code_r,
  input wire logic signed [17:0] ch1_raw,
  input wire logic signed [17:0] ch1_level,
  input wire logic signed [17:0] ch1_noise_margin,
  input wire logic signed [17:0] ch1_break_value,
  input wire logic signed [17:0] ch1_value,
  input wire logic signed [17:0] out_percent_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_above; !ch1_invert && ch1_raw > ch1_level + ch1_noise_margin; endsequence
  sequence s_below; ch1_invert && ch1_raw < ch1_level - ch1_noise_margin; endsequence
  a_eff_decode:
    assert property (ch1_break_enable_eff == (ch1_break_enable && ch1_range_kind inside {4'h1, 4'h3, 4'h6, 4'h7}))
      else $error("bad break enable");
  a_lost_flag:
    assert property (ch1_break_enable_eff && ch1_raw < (ch1_range_kind > 4'h4 ? 18'sh63 : 18'sh64) |=> ch1_lost)
      else $error("break not flagged");
  a_no_flag:
    assert property (!ch1_break_enable_eff |=> !ch1_lost) else $error("flag while disabled");
  a_subst_value:
    assert property (ch1_lost |-> ch1_value == $past(ch1_break_value)) else $error("no substitute");
  a_thr_above:
    assert property (s_above |=> ch1_analog_threshold_input) else $error("comparator low above band");
  a_thr_inverted:
    assert property (s_below |=> ch1_analog_threshold_input) else $error("inverted comparator wrong");
  a_out_clamp:
    assert property (out_percent_r >= 18'sh0 && out_percent_r <= 18'sh7530) else $error("output out of range");
  a_code_top:
    assert property (!$past(srst) && out_percent_r == 18'sh2710 && $past(out_range_kind) != 2'h3
      |-> out_code_r == 16'hffff) else $error("full scale code wrong");
endmodule
bind aio_top aio_top_chk u_aio_top_chk (.*);

/* File: bench/tb.sv */
// ==========================================
// self-checking bench for aio_top
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 0, srst = 1, magnitude_select = 0, ch1_invert = 0, ch2_invert = 0;
  logic               ch1_break_enable = 1, ch2_break_enable = 0;
  logic [3:0]         ch1_range_kind = 4'h0, ch2_range_kind = 4'h0;
  logic [1:0]         out_range_kind = 2'h0;
  logic signed [17:0] ch1_scale = 18'sh2710, ch1_offset = 0, ch1_break_value = 18'sh3039, ch1_level = 0;
  logic signed [17:0] ch2_scale = 18'sh2710, ch2_offset = 0, ch2_break_value = -18'sh309, ch2_level = 0;
  logic signed [17:0] ch1_noise_margin = 0, ch2_noise_margin = 0, out_demand = 0;
  logic signed [17:0] out_scale = 18'sh2710, out_offset = 0;
  wire signed [17:0]  ch1_raw, ch2_raw, ch1_value, ch2_value, out_percent_r;
  wire [15:0]         out_code_r;
  wire                ch1_lost, ch2_lost, ch1_break_enable_eff, ch2_break_enable_eff;
  wire                ch1_analog_threshold_input, ch2_analog_threshold_input;
  int                 lv1 = 0, lv2 = 0, errors = 0, cmp_count = 0, lst[2], p, c;
  int                 lo[9] = '{0, 2000, 0, 1000, 0, 0, 880, 880, 0};
  int                 sp[9] = '{10000, 8000, 5000, 4000, 10000, 4400, 3520, 3520, 4400};
  aio_conv_model u_aio_conv_model1 (.level(lv1), .kind(ch1_range_kind), .raw(ch1_raw));
  aio_conv_model u_aio_conv_model2 (.level(lv2), .kind(ch2_range_kind), .raw(ch2_raw));
  aio_top u_aio_top (.*);
  always #25 clock = ~clock;
  // ==========================================
  // reference model and compares
  function automatic int val(int r, int k, int sc, int of, bit en, int bv, output bit ef, lost);
    int n = (r - lo[k]) * 10000 / sp[k];
    ef = en && k inside {1, 3, 6, 7};
    lost = ef && r < (k > 4 ? 99 : 100);
    n = (k > 6 ? 10000 - n : n) * sc / 10000 + of;
    return lost ? bv : n > 30000 ? 30000 : n < -30000 ? -30000 : n;
  endfunction
  function automatic bit thr(int i, int r, int lv, int m, bit inv);
    int t = lst[i] ? lv - m : lv + m;
    if (r != t) lst[i] = r > t;
    return lst[i] ^ inv;
  endfunction
  task automatic chk_v(input logic [17:0] got, input int exp);
    cmp_count++;
    if (got !== exp[17:0]) begin
      errors++;
      $display("[ERR] %0t value got %0d exp %0d", $time, $signed(got), exp);
    end
  endtask
  task automatic chk_f(input logic [2:0] got, input bit [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flags got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic step;
    bit e1, e2, l1, l2, t1, t2;
    int v1, v2;
    #1;
    v1 = val(ch1_raw, ch1_range_kind, ch1_scale, ch1_offset, ch1_break_enable, ch1_break_value, e1, l1);
    v2 = val(ch2_raw, ch2_range_kind, ch2_scale, ch2_offset, ch2_break_enable, ch2_break_value, e2, l2);
    t1 = thr(0, ch1_raw, ch1_level, ch1_noise_margin, ch1_invert);
    t2 = thr(1, ch2_raw, ch2_level, ch2_noise_margin, ch2_invert);
    p = out_demand * out_scale / 10000 + out_offset;
    if (p < 0) p = magnitude_select ? -p : 0;
    p = p > 30000 ? 30000 : p;
    c = p > 10000 ? 10000 : p;
    c = out_range_kind == 2 ? c * 52428 / 10000 + 13107 : c * 65535 / 10000;
    @(posedge clock);
    #1;
    chk_f({ch1_break_enable_eff, ch1_lost, ch1_analog_threshold_input}, {e1, l1, t1});
    chk_f({ch2_break_enable_eff, ch2_lost, ch2_analog_threshold_input}, {e2, l2, t2});
    chk_v(ch1_value, v1);
    chk_v(ch2_value, v2);
    chk_v(out_percent_r, p);
    chk_v({2'h0, out_code_r}, c);
  endtask
  task automatic stop_test;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    void'($urandom(66));
    repeat (4) @(posedge clock);
    #1 srst = 0;
    foreach (lo[k]) for (int i = 0; i < 3; i++) begin
      ch1_range_kind = 4'(k);
      ch2_range_kind = 4'(8 - k);
      ch2_break_enable = i[0];
      lv1 = i == 0 ? 50 : i == 1 ? 440 : k > 4 ? 20000 : 10000;
      lv2 = lv1;
      step();
    end
    $display("input kinds test done");
    for (int i = 0; i < 12; i++) begin
      out_range_kind = 2'(i % 3);
      magnitude_select = i[0];
      out_demand = i / 3 == 1 ? 18'sh2710 : i / 3 == 2 ? -18'sh2710 : 18'sh0;
      step();
    end
    $display("output kinds test done");
    repeat (500) begin
      lv1 = $urandom_range(12000);
      lv2 = $urandom_range(22000);
      ch1_range_kind = 4'($urandom_range(8));
      ch2_range_kind = 4'($urandom_range(8));
      {ch1_break_enable, ch2_break_enable, ch1_invert, ch2_invert, magnitude_select} = 5'($urandom);
      ch1_scale = 18'($urandom_range(60000) - 30000);
      ch2_scale = 18'($urandom_range(60000) - 30000);
      ch1_offset = 18'($urandom_range(2000) - 1000);
      ch2_offset = 18'($urandom_range(2000) - 1000);
      ch1_break_value = 18'($urandom_range(60000) - 30000);
      ch2_break_value = 18'($urandom_range(60000) - 30000);
      ch1_level = 18'($urandom_range(10000));
      ch2_level = 18'($urandom_range(10000));
      ch1_noise_margin = 18'($urandom_range(1500));
      ch2_noise_margin = 18'($urandom_range(1500));
      out_demand = 18'($urandom_range(60000) - 30000);
      out_scale = 18'($urandom_range(40000) - 20000);
      out_offset = 18'($urandom_range(4000) - 2000);
      out_range_kind = 2'($urandom_range(2));
      step();
    end
    $display("random test done");
    stop_test();
  end
endmodule
